//--- include/fg_pkg.sv
// Constants shared by the resume and sector guard block
//
// Overview of operation
// - Buffer-one transfer refused during buffer-one program pause
// - Compare refused on the buffer whose program paused
// - No deep power-down entry or exit while paused
// - Reads, resets allowed; security programming refused
// - Resume is lone opcode, trailing data ignored
// - Resume continues operation, clears flag, shows busy
// - Both paused: program resumes first, erase later
// - Suspend ignored while resume still in progress
// - Protected sectors block program and erase
// - Status shows protection by command or pin
// - Floating guard pin leaves commands in control
// - Command protection starts disabled after power-up
// - Enable sequence acts only at frame end
// - Disable sequence acts only at frame end
// - Pause flags set while operation paused
// - Disable ignored while guard pin low
package fg_pkg;

  // ---------------------------------------------------------------
  // Opcodes and sequences
  // ---------------------------------------------------------------
  localparam logic [7:0]  OP_RESUME   = 8'hd0;      // Program/erase resume
  localparam logic [7:0]  PROT_BYTE1  = 8'h3d;      // Protection sequence, byte one
  localparam logic [23:0] PROT_PREFIX = 24'h3d2a7f; // First three protection bytes
  localparam logic [7:0]  PROT_ENABLE = 8'ha9;      // Last byte, enable
  localparam logic [7:0]  PROT_DISABLE = 8'h9a;     // Last byte, disable

  // ---------------------------------------------------------------
  // Frame sizes and counters
  // ---------------------------------------------------------------
  localparam logic [5:0]  OPCODE_BITS = 6'h08;      // Bits in one opcode
  localparam logic [5:0]  PROT_BITS   = 6'h20;      // Bits in a protection sequence
  localparam logic [5:0]  BIT_CNT_MAX = 6'h3f;      // Bit counter saturates here
  localparam int          CLK_PERIOD_NS = 10;       // System clock period

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic        SW_PROT_RST = 1'b0;       // Command protection off at power-up
  localparam logic        CS_IDLE     = 1'b1;       // Chip select idles deasserted

endpackage

//--- src/fg_cmd_gate.sv
// Suspend-state admission check for one decoded command
`timescale 1ns/1ns
module fg_cmd_gate
  import fg_pkg::*;
#(
  parameter logic [7:0] OP_XFER1    = 8'h01, // Main memory to buffer one transfer
  parameter logic [7:0] OP_XFER2    = 8'h02, // Main memory to buffer two transfer
  parameter logic [7:0] OP_CMP1     = 8'h03, // Main memory to buffer one compare
  parameter logic [7:0] OP_CMP2     = 8'h04, // Main memory to buffer two compare
  parameter logic [7:0] OP_BUF1_WR  = 8'h05, // Buffer one write
  parameter logic [7:0] OP_BUF2_WR  = 8'h06, // Buffer two write
  parameter logic [7:0] OP_DPD      = 8'h07, // Enter deep power-down
  parameter logic [7:0] OP_DPD_EXIT = 8'h08, // Resume from deep power-down
  parameter logic [7:0] OP_UDPD     = 8'h09, // Enter ultra-deep power-down
  parameter logic [7:0] OP_SEC_PROG = 8'h0c  // Program security register
) (
  // Command under test
  input  wire logic [7:0] opcode,
  input  wire logic       is_prot,
  // Pause flags
  input  wire logic       buf1_paused,
  input  wire logic       buf2_paused,
  input  wire logic       erase_paused,
  // Verdict
  output logic            allowed
);

  logic any_paused; // Some operation is paused

  // ---------------------------------------------------------------
  // Admission table
  // ---------------------------------------------------------------
  always_comb begin
    any_paused = buf1_paused | buf2_paused | erase_paused;
    allowed    = 1'b1;
    if (is_prot) begin
      allowed = !any_paused;                     // Protection sequences barred while paused
    end else begin
      case (opcode)
        OP_XFER1, OP_BUF1_WR: allowed = !buf1_paused;
        OP_XFER2, OP_BUF2_WR: allowed = !buf2_paused;
        OP_CMP1:              allowed = !buf1_paused;
        OP_CMP2:              allowed = !buf2_paused;
        OP_DPD, OP_DPD_EXIT, OP_UDPD: begin
          allowed = !any_paused;
        end
        OP_SEC_PROG:          allowed = !any_paused;
        default:              allowed = 1'b1;
      endcase
    end
  end

endmodule // fg_cmd_gate

//--- src/fg_resume_guard.sv
// Resume handling, suspend admission and software sector protection
`timescale 1ns/1ns
module fg_resume_guard
  import fg_pkg::*;
#(
  parameter logic [7:0] OP_SUSPEND        = 8'h0a, // Program/erase suspend opcode
  parameter int         RESUME_LATENCY_NS = 1000   // Longest resume latency
) (
  // System clock and reset
  input  wire logic        clock,
  input  wire logic        nrst,
  // Serial link
  input  wire logic        sck,
  input  wire logic        cs_n,
  input  wire logic        si,
  // Write-guard pin
  input  wire logic        wp_n,
  // Operation state from the array core
  input  wire logic        core_prog1_run,
  input  wire logic        core_prog2_run,
  input  wire logic        core_erase_run,
  // Program/erase permission request
  input  wire logic        pe_req,
  input  wire logic [3:0]  pe_sector,
  input  wire logic [15:0] prot_map,
  // Command hand-off
  output logic             cmd_accept,
  output logic [7:0]       cmd_opcode,
  output logic             cmd_reject,
  output logic             suspend_req,
  output logic             resume_prog,
  output logic             resume_erase,
  // Status
  output logic             buf_one_prog_paused_flag,
  output logic             buf_two_prog_paused_flag,
  output logic             erase_paused_flag,
  output logic             busy,
  output logic             prot_status,
  output logic             pe_grant,
  output logic             pe_block
);

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int         RES_CYC_INT = RESUME_LATENCY_NS / CLK_PERIOD_NS;
  localparam logic [11:0] RESUME_CYC = (RES_CYC_INT < 1) ? 12'h001 : 12'(RES_CYC_INT);

  // ---------------------------------------------------------------
  // Link domain
  // ---------------------------------------------------------------
  logic        in_frame;  // First edge of the frame has passed
  logic [5:0]  bit_cnt;   // Bits taken in this frame
  logic [31:0] shift;     // First four bytes of the frame
  logic [7:0]  op_byte;   // First byte of the frame

  // Frame start marker, cleared while chip select is high
  always_ff @(posedge sck or posedge cs_n) begin
    if (cs_n) begin
      in_frame <= 1'b0;
    end else begin
      in_frame <= 1'b1;
    end
  end

  // Bit counter, restarts on the first edge of each frame
  always_ff @(posedge sck or negedge nrst) begin
    if (!nrst) begin
      bit_cnt <= 6'h00;
    end else if (!in_frame) begin
      bit_cnt <= 6'h01;
    end else if (bit_cnt != BIT_CNT_MAX) begin
      bit_cnt <= bit_cnt + 6'h01;
    end
  end

  // Shift register keeps only the first four bytes
  always_ff @(posedge sck or negedge nrst) begin
    if (!nrst) begin
      shift <= 32'h0000_0000;
    end else if (!in_frame) begin
      shift <= {31'h0000_0000, si};
    end else if (bit_cnt < PROT_BITS) begin
      shift <= {shift[30:0], si};
    end
  end

  // Opcode byte captured on its eighth bit
  always_ff @(posedge sck or negedge nrst) begin
    if (!nrst) begin
      op_byte <= 8'h00;
    end else if (in_frame && bit_cnt == OPCODE_BITS - 6'h01) begin
      op_byte <= {shift[6:0], si};
    end
  end

  // ---------------------------------------------------------------
  // Synchronisers
  // ---------------------------------------------------------------
  logic cs_s1;  // Chip select, first stage
  logic cs_s2;  // Chip select, second stage
  logic cs_s3;  // Chip select, edge history
  logic wp_s1;  // Guard pin, first stage
  logic wp_s2;  // Guard pin, second stage

  // Chip select: frame words are stable once this has risen
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      cs_s1 <= CS_IDLE;
      cs_s2 <= CS_IDLE;
      cs_s3 <= CS_IDLE;
    end else begin
      cs_s1 <= cs_n;
      cs_s2 <= cs_s1;
      cs_s3 <= cs_s2;
    end
  end

  // Guard pin resets high like the internal pull-up
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      wp_s1 <= 1'b1;
      wp_s2 <= 1'b1;
    end else begin
      wp_s1 <= wp_n;
      wp_s2 <= wp_s1;
    end
  end

  // ---------------------------------------------------------------
  // Frame decode
  // ---------------------------------------------------------------
  logic        frame_ok;      // Frame ended with a whole opcode
  logic        is_prot;       // Exactly a four-byte protection sequence
  logic [7:0]  op;            // Opcode shown to the gate
  logic        legal;         // Admitted in the present pause state
  logic        special;       // Handled here, not forwarded
  logic        prog_running;  // A program is running in the core
  logic        take_resume;   // Resume accepted
  logic        take_suspend;  // Suspend accepted
  logic        take_enable;   // Protection enable accepted
  logic        take_disable;  // Protection disable accepted
  logic        take_fwd;      // Other command forwarded
  logic [11:0] res_cnt;       // Resume latency countdown
  logic        sw_prot;       // Command-controlled protection
  logic        prot_on;       // Protection by command or pin

  fg_cmd_gate u_gate (
    .opcode  (op),
    .is_prot (is_prot),
    .buf1_paused  (buf_one_prog_paused_flag),
    .buf2_paused  (buf_two_prog_paused_flag),
    .erase_paused (erase_paused_flag),
    .allowed (legal)
  );

  // Classify the finished frame
  always_comb begin
    frame_ok     = cs_s2 && !cs_s3 && bit_cnt >= OPCODE_BITS;
    is_prot      = bit_cnt == PROT_BITS && shift[31:8] == PROT_PREFIX;
    op           = is_prot ? PROT_BYTE1 : op_byte;
    prog_running = core_prog1_run | core_prog2_run;
    prot_on      = sw_prot | !wp_s2;
    special      = is_prot ? (shift[7:0] == PROT_ENABLE || shift[7:0] == PROT_DISABLE)
                           : (op == OP_RESUME || op == OP_SUSPEND);
    // Resume ignores trailing bytes; program is preferred over erase
    take_resume  = frame_ok && !is_prot && op == OP_RESUME && legal
                   && (buf_one_prog_paused_flag || buf_two_prog_paused_flag
                       || (erase_paused_flag && !prog_running));
    // Suspend refused while a resume is still settling
    take_suspend = frame_ok && !is_prot && op == OP_SUSPEND && res_cnt == 12'h000
                   && ((core_prog1_run && !buf_one_prog_paused_flag)
                       || (core_prog2_run && !buf_two_prog_paused_flag)
                       || (core_erase_run && !erase_paused_flag));
    take_enable  = frame_ok && is_prot && shift[7:0] == PROT_ENABLE && legal;
    take_disable = frame_ok && is_prot && shift[7:0] == PROT_DISABLE && legal
                   && wp_s2;
    take_fwd     = frame_ok && legal && !special;
  end

  // ---------------------------------------------------------------
  // Command hand-off
  // ---------------------------------------------------------------
  // Forward admitted commands, discard the rest
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      cmd_accept <= 1'b0;
      cmd_opcode <= 8'h00;
      cmd_reject <= 1'b0;
    end else begin
      cmd_accept <= take_fwd;
      if (take_fwd) begin
        cmd_opcode <= op;
      end
      cmd_reject <= frame_ok && !take_fwd && !take_resume && !take_suspend
                    && !take_enable && !take_disable;
    end
  end

  // Suspend and resume strobes to the core
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      suspend_req  <= 1'b0;
      resume_prog  <= 1'b0;
      resume_erase <= 1'b0;
    end else begin
      suspend_req  <= take_suspend;
      resume_prog  <= take_resume && (buf_one_prog_paused_flag || buf_two_prog_paused_flag);
      resume_erase <= take_resume && !buf_one_prog_paused_flag && !buf_two_prog_paused_flag;
    end
  end

  // ---------------------------------------------------------------
  // Pause flags
  // ---------------------------------------------------------------
  // Set on suspend, cleared by the resume that restarts the operation
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      buf_one_prog_paused_flag <= 1'b0;
      buf_two_prog_paused_flag <= 1'b0;
      erase_paused_flag        <= 1'b0;
    end else if (take_suspend) begin
      if (prog_running) begin
        buf_one_prog_paused_flag <= buf_one_prog_paused_flag | core_prog1_run;
        buf_two_prog_paused_flag <= buf_two_prog_paused_flag | core_prog2_run;
      end else begin
        erase_paused_flag <= 1'b1;
      end
    end else if (take_resume) begin
      if (buf_one_prog_paused_flag || buf_two_prog_paused_flag) begin
        buf_one_prog_paused_flag <= 1'b0;
        buf_two_prog_paused_flag <= 1'b0;
      end else begin
        erase_paused_flag <= 1'b0;
      end
    end
  end

  // Resume latency window, during which busy shows
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      res_cnt <= 12'h000;
    end else if (take_resume) begin
      res_cnt <= RESUME_CYC;
    end else if (res_cnt != 12'h000) begin
      res_cnt <= res_cnt - 12'h001;
    end
  end

  // Busy while resuming or while the core works
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      busy <= 1'b0;
    end else begin
      busy <= take_resume || res_cnt > 12'h001 || prog_running || core_erase_run;
    end
  end

  // ---------------------------------------------------------------
  // Sector protection
  // ---------------------------------------------------------------
  // Command protection, off from reset
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      sw_prot <= SW_PROT_RST;
    end else if (take_enable) begin
      sw_prot <= 1'b1;
    end else if (take_disable) begin
      sw_prot <= 1'b0;
    end
  end

  // Status bit follows command or pin
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      prot_status <= SW_PROT_RST;
    end else begin
      prot_status <= prot_on;
    end
  end

  // Program/erase permission for the addressed sector
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      pe_grant <= 1'b0;
      pe_block <= 1'b0;
    end else begin
      pe_grant <= pe_req && !(prot_on && prot_map[pe_sector]);
      pe_block <= pe_req && prot_on && prot_map[pe_sector];
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  logic saw_frame; // Any frame ended since reset

  // Remember that a frame has ended
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      saw_frame <= 1'b0;
    end else if (frame_ok) begin
      saw_frame <= 1'b1;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  sequence s_resume_prog;
    take_resume && buf_one_prog_paused_flag;
  endsequence

  sequence s_prog_restarted;
    !buf_one_prog_paused_flag && resume_prog ##1 busy [*8];
  endsequence

  a_resume_clears_flag: assert property (s_resume_prog |=> s_prog_restarted)
    else $error("resume did not clear flag and show busy");

  a_both_prog_first: assert property (
    take_resume && erase_paused_flag && (buf_one_prog_paused_flag || buf_two_prog_paused_flag)
    |=> erase_paused_flag && resume_prog && !resume_erase)
    else $error("erase resumed before program");

  a_suspend_while_resume: assert property (
    res_cnt != 12'h000 && frame_ok && op == OP_SUSPEND
    |=> !suspend_req && $stable({buf_one_prog_paused_flag, buf_two_prog_paused_flag, erase_paused_flag}))
    else $error("suspend taken during resume");

  a_suspend_sets_flag: assert property (
    take_suspend && core_erase_run && !prog_running |=> erase_paused_flag ##1 erase_paused_flag)
    else $error("erase pause flag not set");

  a_power_up_off: assert property (!saw_frame |-> !sw_prot)
    else $error("protection on before any command");

  a_enable_at_end: assert property ($rose(sw_prot) |-> $past(frame_ok && is_prot))
    else $error("protection enabled outside frame end");

  a_disable_wp_low: assert property (
    frame_ok && is_prot && shift[7:0] == PROT_DISABLE && !wp_s2 |=> $stable(sw_prot))
    else $error("disable obeyed with guard pin low");

  a_status_by_pin: assert property (!wp_s2 |=> prot_status)
    else $error("status misses pin protection");

  a_block_sector: assert property (
    pe_req && prot_on && prot_map[pe_sector] |=> pe_block && !pe_grant)
    else $error("protected sector not blocked");

  a_discard_no_change: assert property (
    frame_ok && !legal && !special
    |=> cmd_reject && !cmd_accept ##1 $stable({buf_one_prog_paused_flag, erase_paused_flag}))
    else $error("refused command had an effect");

endmodule // fg_resume_guard

//--- testbench/fg_host_model.sv
// Host side of the serial link: sends whole command frames
`timescale 1ns/1ns
module fg_host_model (
  // Serial link driven towards the device
  output logic sck,
  output logic cs_n,
  output logic si
);
  // ---------------------------------------------------------------
  // Idle link: clock parked low, select high
  // ---------------------------------------------------------------
  initial begin
    sck  = 1'b0;
    cs_n = 1'b1;
    si   = 1'b0;
  end

  // One frame, MSB first, 160 ns link period, sck stopped outside it
  task automatic send(input logic [39:0] d, input int n);
    int i;
    #37;
    cs_n = 1'b0;
    for (i = n - 1; i >= 0; i--) begin
      si = d[i];
      #80;
      sck = 1'b1;
      #80;
      sck = 1'b0;
    end
    si = ~si; // Released line must not keep the last bit
    #40;
    cs_n = 1'b1;
  endtask
endmodule // fg_host_model

//--- testbench/testbench.sv
// Self-checking bench for the resume and sector guard block
`timescale 1ns/1ns
module testbench;
  import fg_pkg::*;
  // ---------------------------------------------------------------
  // Settings and signals
  // ---------------------------------------------------------------
  localparam logic [7:0] OP_SUSP = 8'h0a; // Suspend opcode at the instance
  localparam int         RES_CYC = 400;   // Resume window in cycles
  logic        clock = 1'b0, nrst = 1'b0, wp_n = 1'b1, pe_req = 1'b0;
  logic [2:0]  core_run = 3'h0;           // Erase, program two, program one
  logic [3:0]  pe_sector = 4'h0;
  logic [15:0] prot_map = 16'h0;
  logic        sck, cs_n, si, cmd_accept, cmd_reject, suspend_req, resume_prog, resume_erase;
  logic        f1, f2, fe, busy, prot_status, pe_grant, pe_block;
  logic [7:0]  cmd_opcode;
  logic [10:0] exp_q[$];                  // Expected events, oldest first
  logic [10:0] got, want;
  logic [31:0] rnd = 32'h32a7d92a;        // Random source state
  int          err_total = 0, n_compared = 0;
  logic [7:0]  g_op [11] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h09, 8'h0c, 8'h55};
  logic [10:0] g_ok [3] = '{11'h42a, 11'h415, 11'h43f}; // Allowed mask per pause kind

  always #5 clock = ~clock;

  fg_host_model i_host (.sck(sck), .cs_n(cs_n), .si(si));
  fg_resume_guard #(.OP_SUSPEND(OP_SUSP), .RESUME_LATENCY_NS(RES_CYC * CLK_PERIOD_NS)) i_fg_resume_guard (
    .clock(clock), .nrst(nrst), .sck(sck), .cs_n(cs_n), .si(si), .wp_n(wp_n),
    .core_prog1_run(core_run[0]), .core_prog2_run(core_run[1]), .core_erase_run(core_run[2]),
    .pe_req(pe_req), .pe_sector(pe_sector), .prot_map(prot_map),
    .cmd_accept(cmd_accept), .cmd_opcode(cmd_opcode), .cmd_reject(cmd_reject),
    .suspend_req(suspend_req), .resume_prog(resume_prog), .resume_erase(resume_erase),
    .buf_one_prog_paused_flag(f1), .buf_two_prog_paused_flag(f2), .erase_paused_flag(fe),
    .busy(busy), .prot_status(prot_status), .pe_grant(pe_grant), .pe_block(pe_block));

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction

  task automatic check_event(input logic [10:0] e, input logic [10:0] g);
    n_compared++;
    if (e !== g) begin
      err_total++;
      $display("unexpected event: expected %h seen %h", e, g);
    end
  endtask

  task automatic check_level(input string nm, input logic [2:0] e, input logic [2:0] g);
    n_compared++;
    if (e !== g) begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask

  // Frame on the link, expected event noted first, then settle time
  task automatic frame(input logic [39:0] d, input int n, input logic [10:0] e);
    if (e !== 11'h0) exp_q.push_back(e);
    i_host.send(d, n);
    repeat (10) @(posedge clock);
  endtask

  // Permission request for one sector
  task automatic perm(input logic [3:0] s, input logic blk);
    @(posedge clock);
    exp_q.push_back(blk ? 11'h700 : 11'h600);
    pe_req    <= 1'b1;
    pe_sector <= s;
    @(posedge clock);
    pe_req <= 1'b0;
    repeat (2) @(posedge clock);
  endtask

  task automatic set_run(input logic [2:0] v);
    @(posedge clock);
    core_run <= v;
  endtask

  task automatic print_verdict();
    $display("compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Watcher: each output event takes the oldest note
  // ---------------------------------------------------------------
  always @(posedge clock) begin
    #1;
    got = cmd_accept ? {3'h1, cmd_opcode} : cmd_reject ? 11'h200 : suspend_req ? 11'h300 :
          resume_prog ? 11'h400 : resume_erase ? 11'h500 : pe_grant ? 11'h600 : pe_block ? 11'h700 : 11'h0;
    if (got !== 11'h0) begin
      want = (exp_q.size() > 0) ? exp_q.pop_front() : 11'h0;
      check_event(want, got);
    end
  end

  // Watchdog sized well beyond the expected run
  initial begin
    #600000;
    err_total++;
    $display("unexpected hang: expected end seen timeout");
    print_verdict();
  end

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    int s, i;
    logic [2:0] run;
    logic [10:0] rk;
    repeat (3) @(posedge clock);
    nrst <= 1'b1;
    repeat (4) @(posedge clock);
    check_level("flags", 3'h0, {fe, f2, f1});
    check_level("prot", 3'h0, {2'h0, prot_status});
    // Each pause kind: admission table, resume, suspend in window
    for (s = 0; s < 3; s++) begin
      run = 3'h1 << s;
      rk  = (s == 2) ? 11'h500 : 11'h400;
      set_run(run);
      frame({32'h0, OP_SUSP}, 8, 11'h300);
      set_run(3'h0);
      check_level("flags", run, {fe, f2, f1});
      for (i = 0; i < 11; i++) frame({32'h0, g_op[i]}, 8, g_ok[s][i] ? {3'h1, g_op[i]} : 11'h200);
      frame(40'h3d2a7fa9, 32, 11'h200);
      check_level("flags", run, {fe, f2, f1});
      check_level("prot", 3'h0, {2'h0, prot_status});
      rnd = lfsr(rnd);
      frame({24'h0, OP_RESUME, rnd[7:0]}, 16, rk);
      check_level("flags", 3'h0, {fe, f2, f1});
      check_level("busy", 3'h1, {2'h0, busy});
      set_run(run);
      frame({32'h0, OP_SUSP}, 8, 11'h200);
      repeat (RES_CYC) @(posedge clock);
      frame({32'h0, OP_SUSP}, 8, 11'h300);
      set_run(3'h0);
      frame({32'h0, OP_RESUME}, 8, rk);
      repeat (RES_CYC) @(posedge clock);
      check_level("busy", 3'h0, {2'h0, busy});
    end
    $display("test pause admission done");
    // Both paused: program first, erase on a later resume
    set_run(3'h4);
    frame({32'h0, OP_SUSP}, 8, 11'h300);
    set_run(3'h1);
    frame({32'h0, OP_SUSP}, 8, 11'h300);
    set_run(3'h0);
    check_level("flags", 3'h5, {fe, f2, f1});
    frame({32'h0, OP_RESUME}, 8, 11'h400);
    check_level("flags", 3'h4, {fe, f2, f1});
    set_run(3'h1);
    frame({32'h0, OP_RESUME}, 8, 11'h200);
    set_run(3'h0);
    repeat (RES_CYC) @(posedge clock);
    frame({32'h0, OP_RESUME}, 8, 11'h500);
    check_level("flags", 3'h0, {fe, f2, f1});
    $display("test double pause done");
    // Protection: enable, permission, guard pin, disable
    rnd = lfsr(rnd);
    @(posedge clock);
    prot_map <= rnd[15:0];
    frame(40'h3d2a7fa9, 32, 11'h0);
    check_level("prot", 3'h1, {2'h0, prot_status});
    for (i = 0; i < 6; i++) begin
      rnd = lfsr(rnd);
      perm(rnd[3:0], prot_map[rnd[3:0]]);
    end
    frame(40'h3d2a7f9b, 32, {3'h1, PROT_BYTE1});
    check_level("prot", 3'h1, {2'h0, prot_status});
    @(posedge clock);
    wp_n <= 1'b0;
    frame(40'h3d2a7f9a, 32, 11'h200);
    check_level("prot", 3'h1, {2'h0, prot_status});
    @(posedge clock);
    wp_n <= 1'b1;
    frame(40'h3d2a7f9a, 32, 11'h0);
    check_level("prot", 3'h0, {2'h0, prot_status});
    perm(4'h3, 1'b0);
    @(posedge clock);
    wp_n <= 1'b0;
    repeat (6) @(posedge clock);
    check_level("prot", 3'h1, {2'h0, prot_status});
    wp_n <= 1'b1;
    repeat (6) @(posedge clock);
    check_level("prot", 3'h0, {2'h0, prot_status});
    frame(40'h3d2a7fa9, 32, 11'h0);
    @(posedge clock);
    nrst <= 1'b0;
    repeat (3) @(posedge clock);
    nrst <= 1'b1;
    repeat (4) @(posedge clock);
    check_level("prot", 3'h0, {2'h0, prot_status});
    frame(40'h3d2a7fa9, 32, 11'h0);
    check_level("prot", 3'h1, {2'h0, prot_status});
    check_level("queue", 3'h0, exp_q.size() > 0 ? 3'h1 : 3'h0);
    $display("test protection done");
    print_verdict();
  end
endmodule // testbench
